// ### inc/lss_map.svh
// Overview of operation
// - Command reg A bits 0-7 drive stages 1-8
// - Command reg B bits 0-7 drive stages 9-16
// - Command reg C bits 0-1 drive stages 17-18
// - Command reg C bits 7-2 read one
// - Fault registers ignore controller writes
// - Fault reg A holds stages 1-4 pairs
// - Fault reg B holds stages 5-8 pairs
// - Fault reg C holds stages 9-12 pairs
// - Fault reg D holds stages 13-16 pairs
// - Fault reg E holds stages 17, 18
// - Codes 11 ok, 10 battery short, 01 open, 00 ground
// - Fault reg E bit 4 shows battery sense
// - Battery flag valid only with supply above 4.5V
// - Battery flag is live, never latched
// - Fault reg E bits 7-5 read one
// - Serial stage on when enabled, reset pin high, unselected, command zero
// - Stages 17, 18 serial command only
// - Clear instruction restores fault registers to ones
// - Clear leaves fault while detector still asserts
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH

// ****************************************************************
// Instruction codes, bits 5..1 of the instruction byte
// ****************************************************************
`define LSS_OP_WR_CMD_A   5'h14
`define LSS_OP_WR_CMD_B   5'h15
`define LSS_OP_WR_CMD_C   5'h16
`define LSS_OP_RD_CMD_A   5'h04
`define LSS_OP_RD_CMD_B   5'h05
`define LSS_OP_RD_CMD_C   5'h06
`define LSS_OP_CLR_FAULT  5'h18
`define LSS_OP_RD_FAULT_A 5'h08
`define LSS_OP_RD_FAULT_B 5'h09
`define LSS_OP_RD_FAULT_C 5'h0A
`define LSS_OP_RD_FAULT_D 5'h0B
`define LSS_OP_RD_FAULT_E 5'h0C

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define LSS_PREFIX_HI      7
`define LSS_PREFIX_LO      6
`define LSS_OP_HI          5
`define LSS_OP_LO          1
`define LSS_RESET_BYTE     8'hFF
`define LSS_RESET_PAIR     2'h3
`define LSS_CMD_C_FILL     6'h3F
`define LSS_FAULT_E_FILL   3'h7

// ****************************************************************
// Fault codes
// ****************************************************************
`define LSS_FAULT_OK       2'h3
`define LSS_FAULT_SHORT_BATT 2'h2
`define LSS_FAULT_OPEN       2'h1
`define LSS_FAULT_SHORT_GND  2'h0

// ****************************************************************
// Frame timing in serial clock edges
// ****************************************************************
`define LSS_INSTR_BITS     5'h08
`define LSS_FRAME_BITS     5'h10
`define LSS_OVERRUN_BITS   5'h11

`endif

// ### inc/lss_pkg.sv
package lss_pkg;

   // Frame phase of the serial slave
   typedef enum logic {
      LSS_IDLE,
      LSS_FRAME
   } lss_phase_type;

   typedef logic [7:0] lss_byte_type;

endpackage

// ### hdl/lss_regs.sv
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_regs #(
   parameter int NUM_STAGES = 18
) (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      spiCsN,
   input  wire logic                      spiClk,
   input  wire logic                      spiMosi,
   output logic                           spiMisoOut,
   output logic                           spiMisoOe,
   input  wire logic [2*NUM_STAGES-1:0]   stageFaultBits,
   input  wire logic                      batterySense,
   input  wire logic                      outputEnablePin,
   input  wire logic                      resetPin,
   input  wire logic [15:0]               stageSourceSelect,
   output lss_pkg::lss_byte_type          faultRegE,
   output logic [NUM_STAGES-1:0]          stageSerialCommand,
   output logic [NUM_STAGES-1:0]          stageOn
);
   import lss_pkg::*;

   // ****************************************************************
   // Behaviour notes
   // ****************************************************************
   // Serial link runs far slower than clk
   // Every pin except source select passes two flops before use
   // Serial clock edges found from the synced level
   // Each serial edge seen about three clk after the pin
   // Serial clock half period must span several clk
   // Frame is instruction byte, then data byte
   // Instruction byte needs zero prefix and even parity
   // Bad instruction byte reads zero and does nothing
   // Reply loaded on falling edge after eighth bit
   // Reply shifts out most significant bit first
   // Reply bits clear when a frame starts, then change only on falling serial edges
   // Data out driven only while chip select is low
   // Writes act only after chip select rises
   // Frames without exactly sixteen bits are dropped
   // Serial clock left running between frames is ignored
   // Command bits low mean the stage is on
   // Reset turns every stage off
   // Fault pairs copy any active detector code
   // Active fault beats a clear in the same cycle
   // Clear restores only pairs whose detector is quiet
   // Battery flag follows the pin, never latched
   // Battery flag meaningless with low logic supply
   // Supply check is left to software
   // Source select taken as same-clock logic
   // Two top stages ignore source select

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   if (NUM_STAGES != 18) begin : gBadStages
      $error("lss_regs serves exactly 18 stages");
   end

   if ($bits(lss_byte_type) != 8) begin : gBadByte
      $error("lss_regs needs 8-bit register bytes");
   end

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [5:0]              pinSyncA;
   logic [5:0]              pinSyncB;
   logic [2*NUM_STAGES-1:0] faultSyncA;
   logic [2*NUM_STAGES-1:0] faultSyncB;
   logic                    sclkPrev;

   // Two flops on each single-bit pin input; serial clock resets to its idle low
   always_ff @(posedge clk) begin
      if (reset) begin
         pinSyncA <= 6'h2F;
         pinSyncB <= 6'h2F;
      end else begin
         pinSyncA <= {spiCsN, spiClk, spiMosi, batterySense, outputEnablePin, resetPin};
         pinSyncB <= pinSyncA;
      end
   end

   // Two flops on every detector input
   always_ff @(posedge clk) begin
      if (reset) begin
         faultSyncA <= '1;
         faultSyncB <= '1;
      end else begin
         faultSyncA <= stageFaultBits;
         faultSyncB <= faultSyncA;
      end
   end

   // Previous serial clock level for edge detection
   always_ff @(posedge clk) begin
      if (reset) begin
         sclkPrev <= 1'b0;
      end else begin
         sclkPrev <= pinSyncB[4];
      end
   end

   logic csActive;
   logic sclkS;
   logic mosiS;
   logic battS;
   logic enS;
   logic rstPinS;
   logic sclkRise;
   logic sclkFall;

   // Synchronised pin views and serial clock edges
   assign csActive = ~pinSyncB[5];
   assign sclkS    = pinSyncB[4];
   assign mosiS    = pinSyncB[3];
   assign battS    = pinSyncB[2];
   assign enS      = pinSyncB[1];
   assign rstPinS  = pinSyncB[0];
   assign sclkRise = sclkS & ~sclkPrev;
   assign sclkFall = ~sclkS & sclkPrev;

   // ****************************************************************
   // Register state
   // ****************************************************************
   lss_phase_type           phase;
   lss_phase_type           next_phase;
   logic [4:0]              bitCount;
   logic [4:0]              next_bitCount;
   logic [7:0]              rxShift;
   logic [7:0]              next_rxShift;
   logic [7:0]              instr;
   logic [7:0]              next_instr;
   logic [7:0]              txShift;
   logic [7:0]              next_txShift;
   logic                    next_spiMisoOe;
   logic [7:0]              cmdA;
   logic [7:0]              next_cmdA;
   logic [7:0]              cmdB;
   logic [7:0]              next_cmdB;
   logic [1:0]              cmdC;
   logic [1:0]              next_cmdC;
   logic [2*NUM_STAGES-1:0] faultCode;
   logic [2*NUM_STAGES-1:0] next_faultCode;
   logic [NUM_STAGES-1:0]   next_stageOn;
   lss_byte_type            next_faultRegE;
   logic                    clearReq;
   logic                    rxOk;
   logic                    instrOk;
   logic [7:0]              readValue;

   // Instruction byte checks: prefix zero, even parity
   assign rxOk    = (rxShift[`LSS_PREFIX_HI:`LSS_PREFIX_LO] == 2'h0) && ~^rxShift;
   assign instrOk = (instr[`LSS_PREFIX_HI:`LSS_PREFIX_LO] == 2'h0) && ~^instr;

   // ****************************************************************
   // Read data selection
   // ****************************************************************
   // Read data for the instruction just received
   always_comb begin
      readValue = 8'h00;
      if (rxOk) begin
         case (rxShift[`LSS_OP_HI:`LSS_OP_LO])
            `LSS_OP_RD_CMD_A:   readValue = cmdA;
            `LSS_OP_RD_CMD_B:   readValue = cmdB;
            `LSS_OP_RD_CMD_C:   readValue = {`LSS_CMD_C_FILL, cmdC};
            `LSS_OP_RD_FAULT_A: readValue = faultCode[7:0];
            `LSS_OP_RD_FAULT_B: readValue = faultCode[15:8];
            `LSS_OP_RD_FAULT_C: readValue = faultCode[23:16];
            `LSS_OP_RD_FAULT_D: readValue = faultCode[31:24];
            `LSS_OP_RD_FAULT_E: readValue = {`LSS_FAULT_E_FILL, battS,
                                             faultCode[35:32]};
            default:            readValue = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // Serial frame engine and reply shifter
   // ****************************************************************
   always_comb begin
      next_phase     = phase;
      next_bitCount  = bitCount;
      next_rxShift   = rxShift;
      next_instr     = instr;
      next_txShift   = txShift;
      next_spiMisoOe = spiMisoOe;
      case (phase)
         LSS_IDLE: begin
            if (csActive) begin
               next_phase     = LSS_FRAME;
               next_bitCount  = 5'h00;
               next_txShift   = 8'h00;
               next_spiMisoOe = 1'b1;
            end
         end
         LSS_FRAME: begin
            if (!csActive) begin
               next_phase     = LSS_IDLE;
               next_spiMisoOe = 1'b0;
            end else if (sclkRise) begin
               next_rxShift = {rxShift[6:0], mosiS};
               if (bitCount != `LSS_OVERRUN_BITS) begin
                  next_bitCount = bitCount + 5'h01;
               end
            end else if (sclkFall) begin
               if (bitCount == `LSS_INSTR_BITS) begin
                  next_instr   = rxShift;
                  next_txShift = readValue;
               end else begin
                  next_txShift = {txShift[6:0], 1'b0};
               end
            end
         end
         default: begin
            next_phase     = LSS_IDLE;
            next_spiMisoOe = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Register writes at the end of a frame
   // ****************************************************************
   logic frameEnd;
   assign frameEnd = (phase == LSS_FRAME) && !csActive;

   // Only a complete 16-bit frame acts; writes to fault registers have no code
   always_comb begin
      next_cmdA = cmdA;
      next_cmdB = cmdB;
      next_cmdC = cmdC;
      clearReq  = 1'b0;
      if (frameEnd && bitCount == `LSS_FRAME_BITS && instrOk) begin
         case (instr[`LSS_OP_HI:`LSS_OP_LO])
            `LSS_OP_WR_CMD_A:  next_cmdA = rxShift;
            `LSS_OP_WR_CMD_B:  next_cmdB = rxShift;
            `LSS_OP_WR_CMD_C:  next_cmdC = rxShift[1:0];
            `LSS_OP_CLR_FAULT: clearReq  = 1'b1;
            default:           clearReq  = 1'b0;
         endcase
      end
   end

   // ****************************************************************
   // Per-stage fault capture and stage control
   // ****************************************************************
   logic [NUM_STAGES-1:0] cmdAll;
   assign cmdAll = {cmdC, cmdB, cmdA};

   for (genvar i = 0; i < NUM_STAGES; i++) begin : gStage
      logic [1:0] detIn;
      assign detIn = faultSyncB[2*i+1:2*i];
      logic       detFault;
      logic [1:0] heldCode;
      // Detector shows a fault; a clear only restores a quiet pair
      assign detFault = (detIn != `LSS_FAULT_OK);
      assign heldCode = clearReq ? `LSS_FAULT_OK : faultCode[2*i+1:2*i];
      // Active fault wins over clear
      assign next_faultCode[2*i+1:2*i] = detFault ? detIn : heldCode;
      if (i < 16) begin : gMux
         assign next_stageOn[i] = enS & rstPinS & ~stageSourceSelect[i] & ~cmdAll[i];
      end else begin : gSerialOnly
         assign next_stageOn[i] = enS & rstPinS & ~cmdAll[i];
      end
   end

   // Live battery flag beside stage 17/18 faults
   assign next_faultRegE = {`LSS_FAULT_E_FILL, battS, next_faultCode[35:32]};

   // ****************************************************************
   // State registers
   // ****************************************************************
   // Frame engine and reply shifter
   always_ff @(posedge clk) begin
      if (reset) begin
         phase     <= LSS_IDLE;
         bitCount  <= 5'h00;
         rxShift   <= 8'h00;
         instr     <= 8'h00;
         txShift   <= 8'h00;
         spiMisoOe <= 1'b0;
      end else begin
         phase     <= next_phase;
         bitCount  <= next_bitCount;
         rxShift   <= next_rxShift;
         instr     <= next_instr;
         txShift   <= next_txShift;
         spiMisoOe <= next_spiMisoOe;
      end
   end

   // ****************************************************************
   // Command register state
   // ****************************************************************
   // Serial command bits, all stages off after reset
   always_ff @(posedge clk) begin
      if (reset) begin
         cmdA <= `LSS_RESET_BYTE;
         cmdB <= `LSS_RESET_BYTE;
         cmdC <= `LSS_RESET_PAIR;
      end else begin
         cmdA <= next_cmdA;
         cmdB <= next_cmdB;
         cmdC <= next_cmdC;
      end
   end

   // ****************************************************************
   // Fault register state
   // ****************************************************************
   // Held fault pairs of all stages
   always_ff @(posedge clk) begin
      if (reset) begin
         faultCode <= '1;
      end else begin
         faultCode <= next_faultCode;
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   // Stage on state and fault register copy
   always_ff @(posedge clk) begin
      if (reset) begin
         faultRegE <= `LSS_RESET_BYTE;
         stageOn   <= '0;
      end else begin
         faultRegE <= next_faultRegE;
         stageOn   <= next_stageOn;
      end
   end

   // ****************************************************************
   // Output assignments
   // ****************************************************************
   // Outputs straight from flops
   assign spiMisoOut         = txShift[7];
   assign stageSerialCommand = {cmdC, cmdB, cmdA};

endmodule // lss_regs

// ### bench/lss_spi_host.sv
`timescale 1ns/100ps
module lss_spi_host (
   output logic      spiCsN,
   output logic      spiClk,
   output logic      spiMosi,
   input  wire logic spiMisoOut,
   input  wire logic spiMisoOe
);
   import lss_pkg::*;
   // Idle bus: clock low and still, chip deselected
   initial begin
      spiCsN = 1'b1;
      spiClk = 1'b0;
      spiMosi = 1'b0;
   end
   // One 16-bit frame, mode 0, MSB first, 48 ns clock
   task automatic frame(input lss_byte_type ins, input lss_byte_type dat, output lss_byte_type rx);
      logic [15:0] tx;
      tx = {ins, dat};
      rx = 8'h00;
      spiCsN = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         spiMosi = tx[i];
         #24 spiClk = 1'b1;
         if (i < 8) rx = {rx[6:0], spiMisoOut & spiMisoOe};
         #24 spiClk = 1'b0;
      end
      #40 spiCsN = 1'b1;
      spiMosi = ~spiMosi; // Released line must not keep the last bit
      #100;
   endtask
endmodule // lss_spi_host

// ### bench/lss_regs_checker.sv
`timescale 1ns/100ps
module lss_regs_checker #(
   parameter int NUM_STAGES = 18
) (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire logic                    spiCsN,
   input wire logic                    spiMisoOe,
   input wire logic [2*NUM_STAGES-1:0] stageFaultBits,
   input wire logic                    batterySense,
   input wire logic                    outputEnablePin,
   input wire logic                    resetPin,
   input wire logic [15:0]             stageSourceSelect,
   input wire lss_pkg::lss_byte_type   faultRegE,
   input wire logic [NUM_STAGES-1:0]   stageSerialCommand,
   input wire logic [NUM_STAGES-1:0]   stageOn
);
   import lss_pkg::*;
   logic [3:0]            sinceReset;
   logic [3:0]            next_sinceReset;
   logic [NUM_STAGES-1:0] expOn;
   // Cycles since reset, saturating
   always_comb begin
      next_sinceReset = (sinceReset == 4'hF) ? sinceReset : sinceReset + 4'h1;
      if (reset) next_sinceReset = 4'h0;
   end
   always_ff @(posedge clk) begin
      sinceReset <= next_sinceReset;
   end
   // Expected serial on state
   assign expOn = {NUM_STAGES{outputEnablePin & resetPin}} & ~stageSerialCommand & ~{2'h0, stageSourceSelect};
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // *****
   // Assertions
   // *****
   a_fill_bits_high: assert property (faultRegE[7:5] == 3'h7) else $error("fill bits low");
   a_reset_values: assert property ($past(reset) |-> stageSerialCommand == '1 && stageOn == '0
      && faultRegE == 8'hFF) else $error("bad reset values");
   a_batt_live: assert property ((sinceReset > 4'h7 && $stable(batterySense))[*6]
      |-> faultRegE[4] == batterySense) else $error("battery flag stale");
   a_stage_on: assert property ((sinceReset > 4'h7 && $stable(expOn))[*5] |-> stageOn == expOn)
      else $error("stage on wrong");
   a_cmd_quiet: assert property ((!spiCsN)[*8] |=> $stable(stageSerialCommand))
      else $error("command moved in frame");
   a_capture_low: assert property ((sinceReset > 4'h7 && $stable(stageFaultBits[33:32])
      && stageFaultBits[33:32] != 2'h3)[*5] |-> faultRegE[1:0] == stageFaultBits[33:32])
      else $error("stage 17 fault lost");
   a_capture_high: assert property ((sinceReset > 4'h7 && $stable(stageFaultBits[35:34])
      && stageFaultBits[35:34] != 2'h3)[*5] |-> faultRegE[3:2] == stageFaultBits[35:34])
      else $error("stage 18 fault lost");
   a_fault_hold: assert property ((sinceReset > 4'h7 && spiCsN && $stable(stageFaultBits))[*8]
      |=> $stable(faultRegE[3:0])) else $error("fault code moved");
   c_frame: cover property (!spiCsN && spiMisoOe);
   c_on: cover property (|stageOn);
   c_batt_low: cover property (!faultRegE[4]);
endmodule // lss_regs_checker

bind lss_regs lss_regs_checker #(.NUM_STAGES(NUM_STAGES)) i_checker (.clk(clk), .reset(reset),
   .spiCsN(spiCsN), .spiMisoOe(spiMisoOe), .stageFaultBits(stageFaultBits), .batterySense(batterySense),
   .outputEnablePin(outputEnablePin), .resetPin(resetPin), .stageSourceSelect(stageSourceSelect),
   .faultRegE(faultRegE), .stageSerialCommand(stageSerialCommand), .stageOn(stageOn));

// ### bench/lss_regs_bench.sv
`timescale 1ns/100ps
module lss_regs_bench;
   import lss_pkg::*;
   typedef struct packed {logic [4:0] op; lss_byte_type dat; lss_byte_type exp;} lss_row_type;
   logic clk, reset, spiCsN, spiClk, spiMosi, spiMisoOut, spiMisoOe, batterySense, outputEnablePin, resetPin;
   logic [35:0]  stageFaultBits;
   logic [15:0]  stageSourceSelect;
   lss_byte_type faultRegE, rx;
   logic [17:0]  stageSerialCommand, stageOn;
   int           err_total, checks;
   lss_row_type  rows [0:11] = '{'{5'h14, 8'h5A, 8'h00}, '{5'h04, 8'h00, 8'h5A}, '{5'h15, 8'hA5, 8'h00},
      '{5'h05, 8'h00, 8'hA5}, '{5'h16, 8'h00, 8'h00}, '{5'h06, 8'h00, 8'hFC}, '{5'h08, 8'h00, 8'h1B},
      '{5'h09, 8'h00, 8'hE4}, '{5'h0A, 8'h00, 8'hFF}, '{5'h0B, 8'h00, 8'h1B}, '{5'h0C, 8'h00, 8'hF9},
      '{5'h1C, 8'h00, 8'h00}};
   lss_regs i_dut (.clk(clk), .reset(reset), .spiCsN(spiCsN), .spiClk(spiClk), .spiMosi(spiMosi),
      .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe), .stageFaultBits(stageFaultBits), .batterySense(batterySense),
      .outputEnablePin(outputEnablePin), .resetPin(resetPin), .stageSourceSelect(stageSourceSelect),
      .faultRegE(faultRegE), .stageSerialCommand(stageSerialCommand), .stageOn(stageOn));
   lss_spi_host i_host (.spiCsN(spiCsN), .spiClk(spiClk), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut),
      .spiMisoOe(spiMisoOe));
   // Instruction byte with even parity
   function automatic lss_byte_type instr(input logic [4:0] op);
      return {2'h0, op, ^op};
   endfunction
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [4:0] op, input lss_byte_type exp);
      i_host.frame(instr(op), 8'h00, rx);
      check(rx, exp);
   endtask
   task automatic results();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      err_total++;
      results();
   end
   // Table cases, then hand-written ones
   initial begin
      reset = 1'b1;
      stageFaultBits = {4'h9, 8'h1B, 8'hFF, 8'hE4, 8'h1B};
      {batterySense, outputEnablePin, resetPin} = 3'h7;
      stageSourceSelect = 16'h00F0;
      repeat (6) @(posedge clk);
      #1 reset = 1'b0;
      repeat (10) @(posedge clk);
      foreach (rows[k]) begin
         i_host.frame(instr(rows[k].op), rows[k].dat, rx);
         if (!rows[k].op[4]) check(rx, rows[k].exp);
      end
      xfer(5'h08, 8'h1B);
      i_host.frame({2'h0, 5'h14, 1'b1}, 8'h00, rx);
      xfer(5'h04, 8'h5A);
      check(stageSerialCommand, 18'h0A55A);
      check(stageOn, 18'h35A05);
      @(posedge clk) #1 outputEnablePin = 1'b0;
      repeat (8) @(posedge clk);
      check(stageOn, 18'h00000);
      #1 outputEnablePin = 1'b1;
      stageFaultBits = {4'hD, 32'hFFFFFFFF};
      repeat (8) @(posedge clk);
      xfer(5'h0C, 8'hF9);
      i_host.frame(instr(5'h18), 8'h00, rx);
      xfer(5'h0C, 8'hFD);
      xfer(5'h08, 8'hFF);
      @(posedge clk) #1 batterySense = 1'b0;
      xfer(5'h0C, 8'hED);
      check(faultRegE, 8'hED);
      @(posedge clk) #1 reset = 1'b1;
      repeat (6) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk) #1;
      check(stageSerialCommand, 18'h3FFFF);
      repeat (10) @(posedge clk);
      xfer(5'h06, 8'hFF);
      xfer(5'h09, 8'hFF);
      results();
   end
endmodule // lss_regs_bench
